// ### logic/sector_map_detect.sv
// Sector map detect: discovery descriptors and per-die architecture bits.
// Assumes register port reads return data one cycle after the strobe.
`timescale 1ns/1ps
`default_nettype none
module sector_map_detect
  import sector_map_pkg::*;
(
  input wire logic I_REF_CLK,
  input wire logic I_ARST_N,
  input wire logic [sector_map_pkg::ADDR_W-1:0] I_ADDR,
  input wire logic [sector_map_pkg::DATA_W-1:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  output logic [sector_map_pkg::DATA_W-1:0] O_RDATA,
  output logic [1:0] O_MAP_IDX,
  output logic O_MAP_ERR
);
  import sector_map_pkg::*;

  logic [7:0] cfg_lo_q;
  logic [7:0] cfg_lo_d;
  logic [7:0] cfg_hi_q;
  logic [7:0] cfg_hi_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic [1:0] idx_q;
  logic err_q;

  wire hit_d1 = (I_ADDR[7:3] == OFS_DET1_W0[7:3]);
  wire hit_d2 = (I_ADDR[7:3] == OFS_DET2_W0[7:3]);
  wire hit_lo = (I_ADDR == OFS_CFG_LO);
  wire hit_hi = (I_ADDR == OFS_CFG_HI);
  wire hit_map = (I_ADDR == OFS_MAP);
  wire [7:0] d1_byte;
  wire [7:0] d2_byte;
  wire lo_arch;
  wire hi_arch;
  wire [1:0] idx_d;
  wire bad_d;

  // Descriptor bytes, fields
  descriptor_word #(.ADDR_WORD(DET1_ADDR)) u_det1 (
    .i_sel(I_ADDR[2:0]),
    .o_byte(d1_byte)
  );
  descriptor_word #(.ADDR_WORD(DET2_ADDR)) u_det2 (
    .i_sel(I_ADDR[2:0]),
    .o_byte(d2_byte)
  );

  // Architecture bits of each die's config reg 3
  assign lo_arch = cfg_lo_q[ARCH_BIT];
  assign hi_arch = cfg_hi_q[ARCH_BIT];
  assign idx_d = {lo_arch, hi_arch};
  // Both hybrid would put small sectors in both dies
  assign bad_d = (idx_d == MAP_BAD);

  always_comb begin
    cfg_lo_d = cfg_lo_q;
    cfg_hi_d = cfg_hi_q;
    if (I_WR && hit_lo) begin
      cfg_lo_d = I_WDATA;
    end
    if (I_WR && hit_hi) begin
      cfg_hi_d = I_WDATA;
    end
  end

  always_comb begin
    rdata_d = 8'h00;
    if (I_RD) begin
      if (hit_d1) begin
        rdata_d = d1_byte;
      end else if (hit_d2) begin
        rdata_d = d2_byte;
      end else if (hit_lo) begin
        rdata_d = cfg_lo_q;
      end else if (hit_hi) begin
        rdata_d = cfg_hi_q;
      end else if (hit_map) begin
        rdata_d = {5'h00, err_q, idx_q};
      end
    end
  end

  always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      cfg_lo_q <= CFG_RESET;
      cfg_hi_q <= CFG_RESET;
      rdata_q <= 8'h00;
      idx_q <= MAP_UNIFORM;
      err_q <= 1'b0;
    end else begin
      cfg_lo_q <= cfg_lo_d;
      cfg_hi_q <= cfg_hi_d;
      rdata_q <= rdata_d;
      idx_q <= idx_d;
      err_q <= bad_d;
    end
  end

  assign O_RDATA = rdata_q;
  assign O_MAP_IDX = idx_q;
  assign O_MAP_ERR = err_q;

  property p_rd_desc1_mask;
    @(posedge I_REF_CLK) disable iff (!I_ARST_N)
    (I_RD && I_ADDR == 8'h4b) |=> (O_RDATA == 8'h08);
  endproperty
  a_rd_desc1_mask: assert property (p_rd_desc1_mask) else $error("mask byte wrong");

  property p_rd_opcode;
    @(posedge I_REF_CLK) disable iff (!I_ARST_N)
    (I_RD && (I_ADDR == 8'h49 || I_ADDR == 8'h51)) |=> (O_RDATA == 8'h65);
  endproperty
  a_rd_opcode: assert property (p_rd_opcode) else $error("opcode byte wrong");

  property p_rd_lenlat;
    @(posedge I_REF_CLK) disable iff (!I_ARST_N)
    (I_RD && I_ADDR == 8'h4a) |=> (O_RDATA[7:6] == 2'h3 && O_RDATA[3:0] == 4'hf);
  endproperty
  a_rd_lenlat: assert property (p_rd_lenlat) else $error("length or latency wrong");

  property p_rd_rsvd_hi;
    @(posedge I_REF_CLK) disable iff (!I_ARST_N)
    (I_RD && I_ADDR == 8'h52) |=> (O_RDATA[5:4] == 2'h3 && O_RDATA[3:0] == 4'hf);
  endproperty
  a_rd_rsvd_hi: assert property (p_rd_rsvd_hi) else $error("reserved high wrong");

  property p_rd_low_byte;
    @(posedge I_REF_CLK) disable iff (!I_ARST_N)
    (I_RD && (I_ADDR == 8'h48 || I_ADDR == 8'h50)) |=> (O_RDATA == 8'hfc);
  endproperty
  a_rd_low_byte: assert property (p_rd_low_byte) else $error("low byte wrong");

  property p_rd_rsvd_lo;
    @(posedge I_REF_CLK) disable iff (!I_ARST_N)
    (I_RD && I_ADDR == 8'h48) |=> (O_RDATA[7:2] == 6'h3f);
  endproperty
  a_rd_rsvd_lo: assert property (p_rd_rsvd_lo) else $error("reserved low wrong");

  property p_rd_addr1;
    @(posedge I_REF_CLK) disable iff (!I_ARST_N)
    (I_RD && I_ADDR == 8'h4c) |=> (O_RDATA == 8'h04);
  endproperty
  a_rd_addr1: assert property (p_rd_addr1) else $error("first address wrong");

  property p_rd_addr2;
    @(posedge I_REF_CLK) disable iff (!I_ARST_N)
    (I_RD && I_ADDR == 8'h57) |=> (O_RDATA == 8'h04);
  endproperty
  a_rd_addr2: assert property (p_rd_addr2) else $error("second address wrong");

  sequence s_cfg_written;
    I_WR && (I_ADDR == 8'h80 || I_ADDR == 8'h81);
  endsequence
  property p_idx_follows;
    @(posedge I_REF_CLK) disable iff (!I_ARST_N)
    s_cfg_written ##1 !I_WR ##1 1'b1 |-> O_MAP_IDX == {cfg_lo_q[3], cfg_hi_q[3]};
  endproperty
  a_idx_follows: assert property (p_idx_follows) else $error("index not joined");

  property p_err_both_hybrid;
    @(posedge I_REF_CLK) disable iff (!I_ARST_N)
    (!cfg_lo_q[3] && !cfg_hi_q[3]) |=> O_MAP_ERR;
  endproperty
  a_err_both_hybrid: assert property (p_err_both_hybrid) else $error("hybrid pair not flagged");

  property p_arch_uniform;
    @(posedge I_REF_CLK) disable iff (!I_ARST_N)
    (I_RD && I_ADDR == 8'h80 && cfg_lo_q[3]) |=> O_RDATA[3];
  endproperty
  a_arch_uniform: assert property (p_arch_uniform) else $error("arch bit lost");

  property p_rd_addr1_up;
    @(posedge I_REF_CLK) disable iff (!I_ARST_N)
    (I_RD && I_ADDR >= 8'h4d && I_ADDR <= 8'h4f) |=> (O_RDATA == 8'h00);
  endproperty
  a_rd_addr1_up: assert property (p_rd_addr1_up) else $error("addr1 upper wrong");

  property p_rd_addr2_lo;
    @(posedge I_REF_CLK) disable iff (!I_ARST_N)
    (I_RD && I_ADDR == 8'h54) |=> (O_RDATA == 8'h04);
  endproperty
  a_rd_addr2_lo: assert property (p_rd_addr2_lo) else $error("addr2 low wrong");

  property p_rd_addr2_mid;
    @(posedge I_REF_CLK) disable iff (!I_ARST_N)
    (I_RD && (I_ADDR == 8'h55 || I_ADDR == 8'h56)) |=> (O_RDATA == 8'h00);
  endproperty
  a_rd_addr2_mid: assert property (p_rd_addr2_mid) else $error("addr2 middle wrong");

  property p_rd_mask2;
    @(posedge I_REF_CLK) disable iff (!I_ARST_N)
    (I_RD && I_ADDR == 8'h53) |=> (O_RDATA == DET_MASK);
  endproperty
  a_rd_mask2: assert property (p_rd_mask2) else $error("mask2 byte wrong");

  property p_rd_lat_var;
    @(posedge I_REF_CLK) disable iff (!I_ARST_N)
    (I_RD && (I_ADDR == 8'h4a || I_ADDR == 8'h52)) |=> (O_RDATA[3:0] == DET_LAT_VAR);
  endproperty
  a_rd_lat_var: assert property (p_rd_lat_var) else $error("latency code wrong");

  property p_rd_len_var2;
    @(posedge I_REF_CLK) disable iff (!I_ARST_N)
    (I_RD && I_ADDR == 8'h52) |=> (O_RDATA[7:6] == DET_ADDR_LEN_VAR);
  endproperty
  a_rd_len_var2: assert property (p_rd_len_var2) else $error("length code wrong");

  property p_rd_rsvd_hi1;
    @(posedge I_REF_CLK) disable iff (!I_ARST_N)
    (I_RD && I_ADDR == 8'h4a) |=> (O_RDATA[5:4] == DET_RSVD_HI);
  endproperty
  a_rd_rsvd_hi1: assert property (p_rd_rsvd_hi1) else $error("reserved hi1 wrong");

  property p_rd_rsvd_lo2;
    @(posedge I_REF_CLK) disable iff (!I_ARST_N)
    (I_RD && I_ADDR == 8'h50) |=> (O_RDATA[7:2] == DET_RSVD_LO);
  endproperty
  a_rd_rsvd_lo2: assert property (p_rd_rsvd_lo2) else $error("reserved lo2 wrong");

  property p_rd_cmd_bits;
    @(posedge I_REF_CLK) disable iff (!I_ARST_N)
    (I_RD && (I_ADDR == 8'h48 || I_ADDR == 8'h50)) |=> (O_RDATA[1:0] == 2'h0);
  endproperty
  a_rd_cmd_bits: assert property (p_rd_cmd_bits) else $error("type bits wrong");

  property p_rd_idle_zero;
    @(posedge I_REF_CLK) disable iff (!I_ARST_N)
    (!I_RD) |=> (O_RDATA == 8'h00);
  endproperty
  a_rd_idle_zero: assert property (p_rd_idle_zero) else $error("idle data not zero");

  property p_rd_unmapped;
    @(posedge I_REF_CLK) disable iff (!I_ARST_N)
    (I_RD && (I_ADDR < OFS_DET1_W0 || (I_ADDR > 8'h57 && I_ADDR < OFS_CFG_LO)
      || I_ADDR > OFS_MAP)) |=> (O_RDATA == 8'h00);
  endproperty
  a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped not zero");

  property p_rd_cfg_lo;
    @(posedge I_REF_CLK) disable iff (!I_ARST_N)
    (I_RD && I_ADDR == OFS_CFG_LO) |=> (O_RDATA == $past(cfg_lo_q));
  endproperty
  a_rd_cfg_lo: assert property (p_rd_cfg_lo) else $error("low cfg read wrong");

  property p_rd_cfg_hi;
    @(posedge I_REF_CLK) disable iff (!I_ARST_N)
    (I_RD && I_ADDR == OFS_CFG_HI) |=> (O_RDATA == $past(cfg_hi_q));
  endproperty
  a_rd_cfg_hi: assert property (p_rd_cfg_hi) else $error("high cfg read wrong");

  property p_rd_map_stat;
    @(posedge I_REF_CLK) disable iff (!I_ARST_N)
    (I_RD && I_ADDR == OFS_MAP) |=> (O_RDATA == {5'h00, $past(O_MAP_ERR), $past(O_MAP_IDX)});
  endproperty
  a_rd_map_stat: assert property (p_rd_map_stat) else $error("map stat wrong");

  property p_wr_lo_lands;
    @(posedge I_REF_CLK) disable iff (!I_ARST_N)
    (I_WR && I_ADDR == OFS_CFG_LO) |=> (cfg_lo_q == $past(I_WDATA));
  endproperty
  a_wr_lo_lands: assert property (p_wr_lo_lands) else $error("low cfg not written");

  property p_wr_hi_lands;
    @(posedge I_REF_CLK) disable iff (!I_ARST_N)
    (I_WR && I_ADDR == OFS_CFG_HI) |=> (cfg_hi_q == $past(I_WDATA));
  endproperty
  a_wr_hi_lands: assert property (p_wr_hi_lands) else $error("high cfg not written");

  sequence s_wr_other;
    I_WR && I_ADDR != OFS_CFG_LO && I_ADDR != OFS_CFG_HI;
  endsequence
  property p_wr_other;
    @(posedge I_REF_CLK) disable iff (!I_ARST_N)
    s_wr_other |=> ($stable(cfg_lo_q) && $stable(cfg_hi_q));
  endproperty
  a_wr_other: assert property (p_wr_other) else $error("stray write landed");

  property p_no_wr_hold;
    @(posedge I_REF_CLK) disable iff (!I_ARST_N)
    (!I_WR) |=> ($stable(cfg_lo_q) && $stable(cfg_hi_q));
  endproperty
  a_no_wr_hold: assert property (p_no_wr_hold) else $error("cfg changed idle");

  property p_err_only_bad;
    @(posedge I_REF_CLK) disable iff (!I_ARST_N)
    O_MAP_ERR |-> (O_MAP_IDX == MAP_BAD);
  endproperty
  a_err_only_bad: assert property (p_err_only_bad) else $error("error on good map");

  property p_err_clears;
    @(posedge I_REF_CLK) disable iff (!I_ARST_N)
    (cfg_lo_q[ARCH_BIT] || cfg_hi_q[ARCH_BIT]) |=> !O_MAP_ERR;
  endproperty
  a_err_clears: assert property (p_err_clears) else $error("error not cleared");

  sequence s_pair_bottom;
    !cfg_lo_q[ARCH_BIT] && cfg_hi_q[ARCH_BIT];
  endsequence
  property p_idx_bottom;
    @(posedge I_REF_CLK) disable iff (!I_ARST_N)
    s_pair_bottom |=> (O_MAP_IDX == MAP_BOTTOM && !O_MAP_ERR);
  endproperty
  a_idx_bottom: assert property (p_idx_bottom) else $error("bottom map wrong");

  sequence s_pair_top;
    cfg_lo_q[ARCH_BIT] && !cfg_hi_q[ARCH_BIT];
  endsequence
  property p_idx_top;
    @(posedge I_REF_CLK) disable iff (!I_ARST_N)
    s_pair_top |=> (O_MAP_IDX == MAP_TOP && !O_MAP_ERR);
  endproperty
  a_idx_top: assert property (p_idx_top) else $error("top map wrong");

  sequence s_pair_uniform;
    cfg_lo_q[ARCH_BIT] && cfg_hi_q[ARCH_BIT];
  endsequence
  property p_idx_uniform;
    @(posedge I_REF_CLK) disable iff (!I_ARST_N)
    s_pair_uniform |=> (O_MAP_IDX == MAP_UNIFORM && !O_MAP_ERR);
  endproperty
  a_idx_uniform: assert property (p_idx_uniform) else $error("uniform map wrong");

  property p_arch_hybrid;
    @(posedge I_REF_CLK) disable iff (!I_ARST_N)
    (I_RD && I_ADDR == OFS_CFG_LO && !cfg_lo_q[ARCH_BIT]) |=> !O_RDATA[ARCH_BIT];
  endproperty
  a_arch_hybrid: assert property (p_arch_hybrid) else $error("hybrid bit lost");

  property p_arch_uni_hi;
    @(posedge I_REF_CLK) disable iff (!I_ARST_N)
    (I_RD && I_ADDR == OFS_CFG_HI && cfg_hi_q[ARCH_BIT]) |=> O_RDATA[ARCH_BIT];
  endproperty
  a_arch_uni_hi: assert property (p_arch_uni_hi) else $error("high uniform lost");

  property p_arch_hyb_hi;
    @(posedge I_REF_CLK) disable iff (!I_ARST_N)
    (I_RD && I_ADDR == OFS_CFG_HI && !cfg_hi_q[ARCH_BIT]) |=> !O_RDATA[ARCH_BIT];
  endproperty
  a_arch_hyb_hi: assert property (p_arch_hyb_hi) else $error("high hybrid lost");
endmodule
`default_nettype wire

// ### shared/sector_map_pkg.sv
// Constants for the sector map configuration detect block.
// Assumes a byte-wide discovery table read and a plain register port.
package sector_map_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  // Descriptor fields
  localparam logic [7:0] DET_MASK = 8'h08;
  localparam logic [1:0] DET_ADDR_LEN_VAR = 2'h3;
  localparam logic [1:0] DET_RSVD_HI = 2'h3;
  localparam logic [3:0] DET_LAT_VAR = 4'hf;
  localparam logic [7:0] DET_OPCODE = 8'h65;
  localparam logic [5:0] DET_RSVD_LO = 6'h3f;
  localparam logic DET_IS_MAP = 1'b0;
  localparam logic DET_IS_END = 1'b0;
  localparam logic [31:0] DET1_ADDR = 32'h00000004;
  localparam logic [31:0] DET2_ADDR = 32'h04000004;
  // Table byte offsets (discovery relative)
  localparam logic [7:0] OFS_DET1_W0 = 8'h48;
  localparam logic [7:0] OFS_DET1_W1 = 8'h4c;
  localparam logic [7:0] OFS_DET2_W0 = 8'h50;
  localparam logic [7:0] OFS_DET2_W1 = 8'h54;
  // Own control/status registers
  localparam logic [7:0] OFS_CFG_LO = 8'h80;
  localparam logic [7:0] OFS_CFG_HI = 8'h81;
  localparam logic [7:0] OFS_MAP = 8'h82;
  localparam int ARCH_BIT = 3;
  localparam logic ARCH_HYBRID = 1'b0;
  localparam logic ARCH_UNIFORM = 1'b1;
  localparam logic [7:0] CFG_RESET = 8'h08;
  typedef enum logic [1:0] {
    MAP_BAD = 2'b00,
    MAP_BOTTOM = 2'b01,
    MAP_TOP = 2'b10,
    MAP_UNIFORM = 2'b11
  } map_idx_t;
endpackage

// ### logic/descriptor_word.sv
// One detection descriptor as eight readable bytes.
// Assumes a byte select from the parent; pure combinational.
`timescale 1ns/1ps
`default_nettype none
module descriptor_word
  import sector_map_pkg::*;
#(
  parameter logic [31:0] ADDR_WORD = 32'h0
) (
  input wire logic [2:0] i_sel,
  output logic [7:0] o_byte
);
  import sector_map_pkg::*;
  logic [31:0] cmd_word;
  logic [63:0] both_words;
  assign cmd_word = {DET_MASK, DET_ADDR_LEN_VAR, DET_RSVD_HI, DET_LAT_VAR,
                     DET_OPCODE, DET_RSVD_LO, DET_IS_MAP, DET_IS_END};
  assign both_words = {ADDR_WORD, cmd_word};
  assign o_byte = both_words[{i_sel, 3'h0} +: 8];
endmodule
`default_nettype wire

// ### tb/host_model.sv
// Host flash controller model: register port master and map detection.
// Assumes the device answers a read in the cycle after the strobe.
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input wire logic i_clk,
  input wire logic [7:0] i_rdata,
  output var logic [7:0] o_addr,
  output var logic [7:0] o_wdata,
  output var logic o_wr,
  output var logic o_rd
);
  initial begin
    o_addr = 8'h00;
    o_wdata = 8'h00;
    o_wr = 1'b0;
    o_rd = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    o_wr <= 1'b1;
    o_addr <= a;
    o_wdata <= d;
    @(posedge i_clk);
    o_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_clk);
    o_rd <= 1'b1;
    o_addr <= a;
    @(posedge i_clk);
    o_rd <= 1'b0;
    #1;
    d = i_rdata;
  endtask
  // Reads both dies, then forms the index from the masked bits only
  task automatic detect(output logic [1:0] idx, output logic bad);
    logic [7:0] m, lo, hi;
    rd(8'h4b, m);
    rd(8'h80, lo);
    rd(8'h81, hi);
    idx = {|(lo & m), |(hi & m)};
    bad = idx == 2'b00;
  endtask
endmodule
`default_nettype wire

// ### tb/testbench.sv
// Testbench: descriptor bytes, config combinations, refusals, reset.
// Assumes the host model is the only register port master.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import sector_map_pkg::*;
  logic clk, arst_n, wr, rd, err, bad;
  logic [7:0] addr, wdata, rdata, d, e;
  logic [1:0] idx, hidx;
  int n_mismatch = 0;
  int n_compared = 0;
  logic [7:0] desc [16] = '{8'hfc, 8'h65, 8'hff, 8'h08, 8'h04, 8'h00, 8'h00, 8'h00,
    8'hfc, 8'h65, 8'hff, 8'h08, 8'h04, 8'h00, 8'h00, 8'h04};
  sector_map_detect i_sector_map_detect (.I_REF_CLK(clk), .I_ARST_N(arst_n),
    .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata),
    .O_MAP_IDX(idx), .O_MAP_ERR(err));
  host_model i_host_model (.i_clk(clk), .i_rdata(rdata), .o_addr(addr),
    .o_wdata(wdata), .o_wr(wr), .o_rd(rd));
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic results;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    arst_n = 1'b0;
    repeat (5) @(posedge clk);
    #1;
    check({5'h0, err, idx}, 8'h03);
    check(rdata, 8'h00);
    @(posedge clk);
    arst_n <= 1'b1;
    for (int k = 0; k < 16; k++) begin
      i_host_model.rd(8'h48 + k[7:0], d);
      check(d, desc[k]);
    end
    $display("descriptor test done");
    for (int c = 0; c < 4; c++) begin
      e = {5'h0, c == 0, c[1:0]};
      i_host_model.wr(8'h80, {4'hf, c[1], 3'h7});
      i_host_model.wr(8'h81, {4'h0, c[0], 3'h0});
      repeat (2) @(posedge clk);
      #1;
      check({5'h0, err, idx}, e);
      i_host_model.rd(8'h82, d);
      check(d, e);
      i_host_model.detect(hidx, bad);
      check({5'h0, bad, hidx}, e);
    end
    $display("config test done");
    i_host_model.wr(8'h82, 8'h00);
    i_host_model.rd(8'h82, d);
    check(d, 8'h03);
    i_host_model.rd(8'h00, d);
    check(d, 8'h00);
    i_host_model.rd(8'h49, d);
    check(d, 8'h65);
    @(posedge clk);
    #1;
    check(rdata, 8'h00);
    $display("refusal test done");
    i_host_model.wr(8'h80, 8'h00);
    @(posedge clk);
    arst_n <= 1'b0;
    #1;
    check({5'h0, err, idx}, 8'h03);
    @(posedge clk);
    arst_n <= 1'b1;
    i_host_model.rd(8'h80, d);
    check(d, 8'h08);
    $display("reset test done");
    results();
  end
endmodule
`default_nettype wire
